// ===== rtl/gpx_defines.vh
// Constants for the serial 16-pin I/O expander
// What this block does
// - Four-wire serial port, serial clock sampled through two flops on the 50 MHz reference clock
// - Command bit 7: one reads, zero writes
// - Command bits 6:1 address, bit 0 reserved
// - Offsets 0x00-0x15: eleven low/high register pairs
// - Reset: drive, direction, filter 0xff; others 0x00
// - Interrupt enable zero means no interrupt
// - Output pins never raise interrupts
// - No edge select: any edge; returning level clears
// - Rise select only: rising edge, read clears
// - Fall select only: falling edge, read clears
// - Both selects: either edge, read clears
// - Filtered edge must hold over 1075 ns
// - State read returns pins, optionally inverted
// - State read clears pending interrupts of group
// - State read shows drive value for outputs
// - Writes to state registers are ignored
// - Output pins driven from drive value
// - Drive value reads back last written value
// - Register MSB is highest pin of group
// - Direction zero is output, one is input
// - Three-state bit one floats output pin
// - Pending registers show interrupting pins, read-only
// - Filter bit zero: any change qualifies
`ifndef GPX_DEFINES_VH
`define GPX_DEFINES_VH
`define GPX_OFF_LEVEL_LO 6'h00
`define GPX_OFF_LEVEL_HI 6'h01
`define GPX_OFF_DRIVE_LO 6'h02
`define GPX_OFF_DRIVE_HI 6'h03
`define GPX_OFF_INVERT_LO 6'h04
`define GPX_OFF_INVERT_HI 6'h05
`define GPX_OFF_DIR_LO 6'h06
`define GPX_OFF_DIR_HI 6'h07
`define GPX_OFF_PULLUP_LO 6'h08
`define GPX_OFF_PULLUP_HI 6'h09
`define GPX_OFF_IRQEN_LO 6'h0a
`define GPX_OFF_IRQEN_HI 6'h0b
`define GPX_OFF_HIZ_LO 6'h0c
`define GPX_OFF_HIZ_HI 6'h0d
`define GPX_OFF_PEND_LO 6'h0e
`define GPX_OFF_PEND_HI 6'h0f
`define GPX_OFF_RISE_LO 6'h10
`define GPX_OFF_RISE_HI 6'h11
`define GPX_OFF_FALL_LO 6'h12
`define GPX_OFF_FALL_HI 6'h13
`define GPX_OFF_FILT_LO 6'h14
`define GPX_OFF_FILT_HI 6'h15
`define GPX_CMD_RW_BIT 7
`define GPX_CMD_ADDR_MSB 6
`define GPX_CMD_ADDR_LSB 1
`define GPX_RST_ONES 8'hff
`define GPX_RST_ZERO 8'h00
`define GPX_CLK_MHZ 50
`define GPX_FILTER_NS 1075
// Cycles strictly above the hold time: floor(ns*MHz/1000)+1
`define GPX_FILTER_CYC ((`GPX_FILTER_NS * `GPX_CLK_MHZ) / 1000 + 1)
`endif

// ===== rtl/gpx_sync.v
// Two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module gpx_sync #(
    parameter WIDTH = 1
) (
    input wire ref_clk_in,
    input wire reset_in,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // First stage is read only by the second stage
    always @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// ===== rtl/gpx_pin_irq.v
// Per-pin edge detect, glitch filter and interrupt pending logic
`timescale 1ns/10ps
`default_nettype none
`include "gpx_defines.vh"
module gpx_pin_irq #(
    parameter FILT_CYC = `GPX_FILTER_CYC
) (
    input wire ref_clk_in,
    input wire reset_in,
    input wire pin_in,
    input wire is_input_in,
    input wire irq_en_in,
    input wire rise_sel_in,
    input wire fall_sel_in,
    input wire filt_en_in,
    input wire read_clr_in,
    output wire pending_out
);
    reg stable_q;
    reg [7:0] hold_q;
    reg snap_q;
    reg pend_q;
    reg seen_q;
    wire armed;
    wire cand;
    wire qual_edge;
    wire rise_edge;
    wire fall_edge;
    wire want;

    // Candidate level differs from the accepted level
    assign cand = (pin_in != stable_q);
    // Unfiltered changes are taken at once; filtered ones after the hold count
    assign qual_edge = cand && (!filt_en_in || (hold_q >= FILT_CYC[7:0] - 8'h01));
    assign rise_edge = qual_edge && pin_in;
    assign fall_edge = qual_edge && !pin_in;
    assign armed = is_input_in && irq_en_in;
    // Edge selection per mode
    assign want = (!rise_sel_in && !fall_sel_in) ? qual_edge :
                  ((rise_sel_in && rise_edge) || (fall_sel_in && fall_edge));

    // Hold counter for the glitch filter and the accepted level
    always @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            stable_q <= 1'b0;
            hold_q <= 8'h00;
            seen_q <= 1'b0;
        end
        else
        begin
            seen_q <= 1'b1;
            if (!seen_q || qual_edge)
            begin
                stable_q <= pin_in;
                hold_q <= 8'h00;
            end
            else if (cand)
                hold_q <= (hold_q == 8'hff) ? hold_q : hold_q + 8'h01;
            else
                hold_q <= 8'h00;
        end
    end

    // Pending flag; in any-edge mode a return to the last-read level cancels it,
    // otherwise a new edge wins over a read clear in the same cycle
    always @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            pend_q <= 1'b0;
            snap_q <= 1'b0;
        end
        else
        begin
            if (read_clr_in || !seen_q)
                snap_q <= pin_in;
            if (!armed)
                pend_q <= 1'b0;
            else if (!rise_sel_in && !fall_sel_in && qual_edge && (pin_in == snap_q))
                pend_q <= 1'b0;
            else if (want && seen_q)
                pend_q <= 1'b1;
            else if (read_clr_in)
                pend_q <= 1'b0;
        end
    end

    assign pending_out = pend_q;
endmodule
`default_nettype wire

// ===== rtl/gpx_top.v
// Serial-port 16-pin I/O expander: serial slave, register bank, pins
`timescale 1ns/10ps
`default_nettype none
`include "gpx_defines.vh"
module gpx_top #(
    parameter PINS = 16,
    parameter FILT_CYC = `GPX_FILTER_CYC
) (
    input wire ref_clk_in,
    input wire reset_in,
    input wire sclk_in,
    input wire sel_n_in,
    input wire sdi_in,
    output wire sdo_out,
    output wire sdo_oe_n_out,
    input wire [PINS-1:0] io_pins_in,
    output wire [PINS-1:0] io_pins_out,
    output wire [PINS-1:0] io_pins_oe_n_out,
    output wire [PINS-1:0] pullup_en_out,
    output wire irq_n_out,
    output wire irq_n_oe_n_out
);
    localparam ST_CMD = 2'd0;
    localparam ST_DATA = 2'd1;
    localparam ST_DONE = 2'd2;

    wire sclk_s;
    wire sel_n_s;
    wire sdi_s;
    wire [PINS-1:0] pins_s;
    reg sclk_prev_q;
    reg [1:0] state_q;
    reg [2:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg rd_q;
    reg [5:0] addr_q;
    reg [7:0] tx_q;
    reg sdo_q;
    reg [PINS-1:0] drive_q;
    reg [PINS-1:0] invert_q;
    reg [PINS-1:0] dir_q;
    reg [PINS-1:0] pullup_q;
    reg [PINS-1:0] irqen_q;
    reg [PINS-1:0] hiz_q;
    reg [PINS-1:0] rise_q;
    reg [PINS-1:0] fall_q;
    reg [PINS-1:0] filt_q;
    reg [PINS-1:0] out_q;
    reg [PINS-1:0] oe_n_q;
    reg irq_n_q;
    reg [1:0] rd_clr_q;
    wire [PINS-1:0] pend;
    wire [PINS-1:0] state_view;
    wire sclk_rise;
    wire sclk_fall;
    wire [7:0] cmd_now;
    wire [PINS-1:0] clr_vec;

    // Read mux for one register offset
    function [7:0] reg_read;
        input [5:0] addr;
        input [PINS-1:0] view;
        begin
            case (addr)
                `GPX_OFF_LEVEL_LO: reg_read = view[7:0];
                `GPX_OFF_LEVEL_HI: reg_read = view[15:8];
                `GPX_OFF_DRIVE_LO: reg_read = drive_q[7:0];
                `GPX_OFF_DRIVE_HI: reg_read = drive_q[15:8];
                `GPX_OFF_INVERT_LO: reg_read = invert_q[7:0];
                `GPX_OFF_INVERT_HI: reg_read = invert_q[15:8];
                `GPX_OFF_DIR_LO: reg_read = dir_q[7:0];
                `GPX_OFF_DIR_HI: reg_read = dir_q[15:8];
                `GPX_OFF_PULLUP_LO: reg_read = pullup_q[7:0];
                `GPX_OFF_PULLUP_HI: reg_read = pullup_q[15:8];
                `GPX_OFF_IRQEN_LO: reg_read = irqen_q[7:0];
                `GPX_OFF_IRQEN_HI: reg_read = irqen_q[15:8];
                `GPX_OFF_HIZ_LO: reg_read = hiz_q[7:0];
                `GPX_OFF_HIZ_HI: reg_read = hiz_q[15:8];
                `GPX_OFF_PEND_LO: reg_read = pend[7:0];
                `GPX_OFF_PEND_HI: reg_read = pend[15:8];
                `GPX_OFF_RISE_LO: reg_read = rise_q[7:0];
                `GPX_OFF_RISE_HI: reg_read = rise_q[15:8];
                `GPX_OFF_FALL_LO: reg_read = fall_q[7:0];
                `GPX_OFF_FALL_HI: reg_read = fall_q[15:8];
                `GPX_OFF_FILT_LO: reg_read = filt_q[7:0];
                `GPX_OFF_FILT_HI: reg_read = filt_q[15:8];
                default: reg_read = 8'h00;
            endcase
        end
    endfunction

    // All serial lines and pins pass two flops before use
    gpx_sync #(
        .WIDTH(3 + PINS)
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .async_in({sclk_in, sel_n_in, sdi_in, io_pins_in}),
        .sync_out({sclk_s, sel_n_s, sdi_s, pins_s})
    );

    // Edge finder on the sampled serial clock
    always @(posedge ref_clk_in)
    begin
        if (reset_in)
            sclk_prev_q <= 1'b0;
        else
            sclk_prev_q <= sclk_s;
    end

    assign sclk_rise = !sel_n_s && sclk_s && !sclk_prev_q;
    assign sclk_fall = !sel_n_s && !sclk_s && sclk_prev_q;
    assign cmd_now = {shift_q[6:0], sdi_s};

    // Pin state view: outputs show drive value, inputs the inverted-if-set pin
    assign state_view = (~dir_q & drive_q) | (dir_q & (pins_s ^ invert_q));

    // A finished state read clears the pending bits of its group
    assign clr_vec = {{8{rd_clr_q[1]}}, {8{rd_clr_q[0]}}};

    // Serial slave: command byte then one data byte, MSB first
    always @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            state_q <= ST_CMD;
            bit_cnt_q <= 3'd0;
            shift_q <= 8'h00;
            rd_q <= 1'b0;
            addr_q <= 6'h00;
            tx_q <= 8'h00;
            sdo_q <= 1'b0;
            rd_clr_q <= 2'b00;
        end
        else
        begin
            rd_clr_q <= 2'b00;
            if (sel_n_s)
            begin
                state_q <= ST_CMD;
                bit_cnt_q <= 3'd0;
            end
            else
            begin
                if (sclk_rise)
                begin
                    shift_q <= cmd_now;
                    bit_cnt_q <= bit_cnt_q + 3'd1;
                    if (bit_cnt_q == 3'd7)
                    begin
                        case (state_q)
                            ST_CMD:
                            begin
                                rd_q <= cmd_now[`GPX_CMD_RW_BIT];
                                addr_q <= cmd_now[`GPX_CMD_ADDR_MSB:`GPX_CMD_ADDR_LSB];
                                tx_q <= reg_read(cmd_now[`GPX_CMD_ADDR_MSB:`GPX_CMD_ADDR_LSB], state_view);
                                state_q <= ST_DATA;
                            end
                            ST_DATA:
                            begin
                                state_q <= ST_DONE;
                                if (rd_q && addr_q == `GPX_OFF_LEVEL_LO)
                                    rd_clr_q[0] <= 1'b1;
                                if (rd_q && addr_q == `GPX_OFF_LEVEL_HI)
                                    rd_clr_q[1] <= 1'b1;
                            end
                            default:
                                state_q <= ST_DONE;
                        endcase
                    end
                end
                if (sclk_fall && state_q == ST_DATA)
                begin
                    sdo_q <= tx_q[7];
                    tx_q <= {tx_q[6:0], 1'b0};
                end
            end
        end
    end

    // Register writes at the end of the data byte
    always @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            drive_q <= {2{`GPX_RST_ONES}};
            dir_q <= {2{`GPX_RST_ONES}};
            filt_q <= {2{`GPX_RST_ONES}};
            invert_q <= {2{`GPX_RST_ZERO}};
            pullup_q <= {2{`GPX_RST_ZERO}};
            irqen_q <= {2{`GPX_RST_ZERO}};
            hiz_q <= {2{`GPX_RST_ZERO}};
            rise_q <= {2{`GPX_RST_ZERO}};
            fall_q <= {2{`GPX_RST_ZERO}};
        end
        else if (!sel_n_s && sclk_rise && bit_cnt_q == 3'd7 && state_q == ST_DATA && !rd_q)
        begin
            // State and pending offsets fall to default and are ignored
            case (addr_q)
                `GPX_OFF_DRIVE_LO: drive_q[7:0] <= cmd_now;
                `GPX_OFF_DRIVE_HI: drive_q[15:8] <= cmd_now;
                `GPX_OFF_INVERT_LO: invert_q[7:0] <= cmd_now;
                `GPX_OFF_INVERT_HI: invert_q[15:8] <= cmd_now;
                `GPX_OFF_DIR_LO: dir_q[7:0] <= cmd_now;
                `GPX_OFF_DIR_HI: dir_q[15:8] <= cmd_now;
                `GPX_OFF_PULLUP_LO: pullup_q[7:0] <= cmd_now;
                `GPX_OFF_PULLUP_HI: pullup_q[15:8] <= cmd_now;
                `GPX_OFF_IRQEN_LO: irqen_q[7:0] <= cmd_now;
                `GPX_OFF_IRQEN_HI: irqen_q[15:8] <= cmd_now;
                `GPX_OFF_HIZ_LO: hiz_q[7:0] <= cmd_now;
                `GPX_OFF_HIZ_HI: hiz_q[15:8] <= cmd_now;
                `GPX_OFF_RISE_LO: rise_q[7:0] <= cmd_now;
                `GPX_OFF_RISE_HI: rise_q[15:8] <= cmd_now;
                `GPX_OFF_FALL_LO: fall_q[7:0] <= cmd_now;
                `GPX_OFF_FALL_HI: fall_q[15:8] <= cmd_now;
                `GPX_OFF_FILT_LO: filt_q[7:0] <= cmd_now;
                `GPX_OFF_FILT_HI: filt_q[15:8] <= cmd_now;
                default: ;
            endcase
        end
    end

    // Per-pin interrupt logic
    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1)
        begin : g_pin
            gpx_pin_irq #(
                .FILT_CYC(FILT_CYC)
            ) u_irq (
                .ref_clk_in(ref_clk_in),
                .reset_in(reset_in),
                .pin_in(pins_s[g]),
                .is_input_in(dir_q[g]),
                .irq_en_in(irqen_q[g]),
                .rise_sel_in(rise_q[g]),
                .fall_sel_in(fall_q[g]),
                .filt_en_in(filt_q[g]),
                .read_clr_in(clr_vec[g]),
                .pending_out(pend[g])
            );
        end
    endgenerate

    // Pin drivers and open-drain interrupt line
    always @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            out_q <= {PINS{1'b1}};
            oe_n_q <= {PINS{1'b1}};
            irq_n_q <= 1'b1;
        end
        else
        begin
            out_q <= drive_q;
            oe_n_q <= dir_q | hiz_q;
            irq_n_q <= ~(|pend);
        end
    end

    assign io_pins_out = out_q;
    assign io_pins_oe_n_out = oe_n_q;
    assign pullup_en_out = pullup_q;
    assign sdo_out = sdo_q;
    assign sdo_oe_n_out = sel_n_s | (state_q != ST_DATA) | !rd_q;
    assign irq_n_out = 1'b0;
    assign irq_n_oe_n_out = irq_n_q;
endmodule
`default_nettype wire

// ===== testbench/gpx_checker.sv
// Port-level assertions for the serial I/O expander
`timescale 1ns/10ps
`default_nettype none
module gpx_checker #(
    parameter PINS = 16,
    parameter FILT_CYC = 54
) (
    input wire ref_clk_in,
    input wire reset_in,
    input wire sclk_in,
    input wire sel_n_in,
    input wire sdi_in,
    input wire sdo_out,
    input wire sdo_oe_n_out,
    input wire [PINS-1:0] io_pins_in,
    input wire [PINS-1:0] io_pins_out,
    input wire [PINS-1:0] io_pins_oe_n_out,
    input wire [PINS-1:0] pullup_en_out,
    input wire irq_n_out,
    input wire irq_n_oe_n_out
);
    localparam int LIM = FILT_CYC + 8;
    logic [PINS-1:0] prev_q;
    logic [7:0] quiet_q;
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);
    // Cycles since any pin last moved, saturating
    always @(posedge ref_clk_in)
    begin
        prev_q <= io_pins_in;
        if (reset_in || io_pins_in != prev_q)
            quiet_q <= 8'h00;
        else if (quiet_q != 8'hff)
            quiet_q <= quiet_q + 8'h01;
    end
    // Serial port behaviour
    property p_sdo_float; sel_n_in [*5] |-> sdo_oe_n_out; endproperty
    a_sdo_float: assert property (p_sdo_float) else $error("sdo driven while deselected");
    property p_sdo_sel; !sdo_oe_n_out |-> !$past(sel_n_in, 4); endproperty
    a_sdo_sel: assert property (p_sdo_sel) else $error("sdo driven without select");
    property p_data_byte; $fell(sdo_oe_n_out) |-> !sdo_oe_n_out [*8]; endproperty
    a_data_byte: assert property (p_data_byte) else $error("read byte cut short");
    property p_sdo_steady; (sclk_in && !sdo_oe_n_out) [*5] |-> $stable(sdo_out); endproperty
    a_sdo_steady: assert property (p_sdo_steady) else $error("sdo moved while clock high");
    // Pins and interrupt line
    property p_irq_data; irq_n_out == 1'b0; endproperty
    a_irq_data: assert property (p_irq_data) else $error("interrupt line drives high");
    property p_reset_out; $fell(reset_in) |-> &io_pins_oe_n_out && &io_pins_out && !(|pullup_en_out); endproperty
    a_reset_out: assert property (p_reset_out) else $error("pin outputs not at reset state");
    property p_pins_quiet; sel_n_in [*8] |-> $stable(io_pins_out) && $stable(io_pins_oe_n_out); endproperty
    a_pins_quiet: assert property (p_pins_quiet) else $error("pins changed with no access");
    property p_irq_cause; $fell(irq_n_oe_n_out) |-> quiet_q <= LIM; endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without a pin edge");
    c_irq: cover property ($fell(irq_n_oe_n_out));
    c_read: cover property ($fell(sdo_oe_n_out));
    c_drive: cover property ($changed(io_pins_oe_n_out));
endmodule
bind gpx_top gpx_checker #(.PINS(PINS), .FILT_CYC(FILT_CYC)) u_chk (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .sclk_in(sclk_in), .sel_n_in(sel_n_in), .sdi_in(sdi_in), .sdo_out(sdo_out), .sdo_oe_n_out(sdo_oe_n_out),
    .io_pins_in(io_pins_in), .io_pins_out(io_pins_out), .io_pins_oe_n_out(io_pins_oe_n_out),
    .pullup_en_out(pullup_en_out), .irq_n_out(irq_n_out), .irq_n_oe_n_out(irq_n_oe_n_out));
`default_nettype wire

// ===== testbench/gpx_spi_master.sv
// Serial master model for the expander's four-wire port
`timescale 1ns/10ps
`default_nettype none
module gpx_spi_master (
    input wire logic ref_clk_in,
    input wire logic sdo_in,
    input wire logic sdo_oe_n_in,
    output logic sclk_out,
    output logic sel_n_out,
    output logic sdi_out
);
    int half = 4;
    // Idle: deselected, clock low
    initial
    begin
        sclk_out = 1'b0;
        sel_n_out = 1'b1;
        sdi_out = 1'b0;
    end
    // One selection, MSB first; nb below 16 aborts the frame
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int nb, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, wd};
        rd = 8'h00;
        @(posedge ref_clk_in);
        sel_n_out <= 1'b0;
        for (int i = 0; i < nb; i++)
        begin
            sdi_out <= sh[15-i];
            repeat (half) @(posedge ref_clk_in);
            sclk_out <= 1'b1;
            rd = {rd[6:0], sdo_oe_n_in ? 1'bx : sdo_in};
            repeat (half) @(posedge ref_clk_in);
            sclk_out <= 1'b0;
        end
        repeat (half) @(posedge ref_clk_in);
        sel_n_out <= 1'b1;
        sdi_out <= ~sdi_out; // Released line shows no stale bit
        repeat (2 * half) @(posedge ref_clk_in);
    endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the serial I/O expander
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) \
        begin \
            $display("wrong value %s expected %h seen %h", nm, ex, got); \
            n_fail++; \
        end \
    end
module testbench;
    localparam int FC = 4;
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [15:0] ext_q = 16'h0000;
    logic [7:0] r;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    wire sclk, sel_n, sdi, sdo, sdo_oe_n, irq, irq_oe_n;
    wire [15:0] io_out, io_oe_n, pu;
    // Pin level: the expander's own drive wins where enabled
    wire [15:0] pin_wire = (io_oe_n & ext_q) | (~io_oe_n & io_out);
    always #10 ref_clk_in = ~ref_clk_in;
    gpx_spi_master m (.ref_clk_in(ref_clk_in), .sdo_in(sdo), .sdo_oe_n_in(sdo_oe_n), .sclk_out(sclk),
        .sel_n_out(sel_n), .sdi_out(sdi));
    gpx_top #(.FILT_CYC(FC)) uut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .sclk_in(sclk), .sel_n_in(sel_n),
        .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n), .io_pins_in(pin_wire), .io_pins_out(io_out),
        .io_pins_oe_n_out(io_oe_n), .pullup_en_out(pu), .irq_n_out(irq), .irq_n_oe_n_out(irq_oe_n));
    // Bus access helpers
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] x;
        m.xfer({1'b0, a, 1'b0}, d, 16, x);
    endtask
    task automatic chk_rd(input string nm, input logic [5:0] a, input logic [7:0] ex);
        logic [7:0] x;
        m.xfer({1'b1, a, 1'b0}, 8'h00, 16, x);
        `CHK(nm, ex, x)
    endtask
    task automatic do_reset;
        @(posedge ref_clk_in);
        reset_in <= 1'b1;
        ext_q <= 16'h0000;
        repeat (8) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
    endtask
    task automatic settle;
        repeat (20) @(posedge ref_clk_in);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Cuts a hang short
    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            summarize();
        end
    end
    // Test sequence
    initial
    begin
        do_reset();
        `CHK("pin enables", 16'hffff, io_oe_n)
        for (int a = 2; a < 23; a++)
            chk_rd("reset value", a[5:0], (a inside {2, 3, 6, 7, 20, 21}) ? 8'hff : 8'h00);
        $display("test reset values done");
        ext_q <= 16'h3cf2;
        for (int a = 0; a < 23; a++)
            wr(a[5:0], 8'h5a ^ a[7:0]);
        chk_rd("state low", 6'h00, (8'h58 & ~8'h5c) | ((8'hf2 ^ 8'h5e) & 8'h5c));
        for (int a = 2; a < 23; a++)
            chk_rd("readback", a[5:0], (a inside {14, 15, 22}) ? 8'h00 : 8'h5a ^ a[7:0]);
        `CHK("pin drive", 16'h5958, io_out)
        `CHK("pin enables", 16'h5f5e, io_oe_n)
        `CHK("pull-ups", 16'h5352, pu)
        m.xfer(8'h08, 8'hff, 12, r);
        chk_rd("aborted write", 6'h04, 8'h5e);
        m.xfer(8'h09, 8'h77, 16, r);
        chk_rd("reserved bit", 6'h04, 8'h77);
        $display("test registers done");
        for (int md = 0; md < 4; md++)
        begin
            do_reset();
            wr(6'h0b, 8'h01);
            wr(6'h15, 8'h00);
            wr(6'h11, {7'h00, md[0]});
            wr(6'h13, {7'h00, md[1]});
            ext_q[8] <= 1'b1;
            settle();
            chk_rd("after rise", 6'h0f, {7'h00, md != 2});
            `CHK("irq after rise", md == 2, irq_oe_n)
            ext_q[8] <= 1'b0;
            settle();
            chk_rd("after fall", 6'h0f, {7'h00, md != 0});
            chk_rd("state high", 6'h01, 8'h00);
            chk_rd("after read", 6'h0f, 8'h00);
            `CHK("irq released", 1'b1, irq_oe_n)
        end
        $display("test edge modes done");
        do_reset();
        wr(6'h0a, 8'hff);
        wr(6'h14, 8'h00);
        wr(6'h06, 8'hf0);
        wr(6'h02, 8'h05);
        ext_q <= 16'h0f00;
        settle();
        chk_rd("output pins", 6'h0e, 8'h00);
        chk_rd("disabled pins", 6'h0f, 8'h00);
        ext_q[4] <= 1'b1;
        settle();
        chk_rd("enabled input", 6'h0e, 8'h10);
        $display("test masking done");
        do_reset();
        wr(6'h0a, 8'h01);
        ext_q[0] <= 1'b1;
        repeat (FC - 1) @(posedge ref_clk_in);
        ext_q[0] <= 1'b0;
        settle();
        chk_rd("short pulse", 6'h0e, 8'h00);
        ext_q[0] <= 1'b1;
        settle();
        chk_rd("held level", 6'h0e, 8'h01);
        wr(6'h14, 8'h00);
        wr(6'h10, 8'h01);
        chk_rd("state low", 6'h00, 8'h01);
        ext_q[0] <= 1'b0;
        settle();
        chk_rd("fall in rise mode", 6'h0e, 8'h00);
        ext_q[0] <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        ext_q[0] <= 1'b0;
        settle();
        chk_rd("unfiltered pulse", 6'h0e, 8'h01);
        $display("test filter done");
        summarize();
    end
endmodule
`default_nettype wire
